// File: sahp_top.sv
// host port and successive-approximation sequencer of a 12-bit converter
// assumes comparator result and conversion clock synchronous to clk_in
`timescale 1ns/100ps
`default_nettype none
// Operation
// - data lines driven only while chip select and read strobe are low.
// - byte select high gives upper byte, low gives lower eight bits.
// - upper byte drives bits 6..4 zero and result 11..8 on bits 3..0.
// - upper byte bit 7 is the busy status, one during conversion.
// - result is twelve bits, bit 11 most significant.
// - chip select active low gates both strobes.
// - qualified write low begins a new conversion with autozero.
// - busy output low during conversion, high otherwise.
// - conversion runs from one clock, internal or external source.
// - write during a conversion aborts it and restarts from the beginning.
// - read during conversion returns partial approximation register contents.
// - external mode decides msb on second falling clock edge after write.
module sahp_top
    import sahp_pkg::*;
(
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    input  wire sahp_pkg::sahp_host_type     host_in,
    input  wire logic                        ext_clk_mode_in,
    input  wire logic                        conv_clk_in,
    input  wire logic                        comp_in,
    output var  logic [sahp_pkg::RES_W-1:0]  dac_code_out,
    output var  logic                        autozero_cap_node_out,
    output var  logic                        busy_n_out,
    output var  sahp_pkg::sahp_bus_type      bus_out
);
    import sahp_pkg::*;

    typedef struct packed {
        sahp_phase_type           phase;
        logic [RES_W-1:0]         sar;
        logic [BIT_CNT_W-1:0]     bit_idx;
        logic [AZ_CNT_W-1:0]      az_cnt;
        logic [1:0]               fall_cnt;
        logic                     cclk_q;
        logic                     wr_q;
    } sahp_state_type;

    sahp_state_type state;
    sahp_state_type next_state;
    logic           wr_act;
    logic           wr_rise;
    logic           cclk_fall;
    logic           busy;

    // =========================================================
    // sequencer
    always_comb begin
        next_state = state;
        wr_act = !host_in.cs_n && !host_in.wr_n;
        wr_rise = state.wr_q && !wr_act;
        cclk_fall = state.cclk_q && !conv_clk_in;
        next_state.wr_q = wr_act;
        next_state.cclk_q = conv_clk_in;
        unique case (state.phase)
            SAHP_IDLE: begin
            end
            SAHP_ARMED: begin
                if (wr_rise) begin
                    next_state.phase = SAHP_WAIT;
                end
            end
            SAHP_WAIT: begin
                if (ext_clk_mode_in) begin
                    if (cclk_fall) begin
                        next_state.fall_cnt = state.fall_cnt + EDGE_FIRST;
                    end
                    if (cclk_fall && state.fall_cnt == EDGE_FIRST) begin
                        next_state.phase = SAHP_CONV;
                        next_state.sar[state.bit_idx] = comp_in;
                        next_state.bit_idx = state.bit_idx - 4'h1;
                        if (state.bit_idx != BIT_LAST) begin
                            next_state.sar[state.bit_idx - 4'h1] = 1'b1;
                        end
                    end
                end else begin
                    if (state.az_cnt != '0) begin
                        next_state.az_cnt = state.az_cnt - 11'h001;
                    end else begin
                        next_state.phase = SAHP_CONV;
                    end
                end
            end
            SAHP_CONV: begin
                if (cclk_fall) begin
                    next_state.sar[state.bit_idx] = comp_in;
                    if (state.bit_idx == BIT_LAST) begin
                        next_state.phase = SAHP_IDLE;
                    end else begin
                        next_state.bit_idx = state.bit_idx - 4'h1;
                        next_state.sar[state.bit_idx - 4'h1] = 1'b1;
                    end
                end
            end
        endcase
        if (wr_act && !state.wr_q) begin
            next_state.phase = SAHP_ARMED;
            next_state.sar = RES_ZERO;
            next_state.sar[MSB_IDX] = 1'b1;
            next_state.bit_idx = BIT_FIRST;
            next_state.az_cnt = AZ_CNT_W'(AUTOZERO_CYC);
            next_state.fall_cnt = EDGE_ZERO;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= '{phase: SAHP_IDLE, default: '0};
        end else begin
            state <= next_state;
        end
    end

    // =========================================================
    // outputs
    assign busy = (state.phase != SAHP_IDLE);
    assign busy_n_out = !busy;
    assign dac_code_out = state.sar;
    assign autozero_cap_node_out = (state.phase == SAHP_IDLE) ||
                                   (state.phase == SAHP_ARMED) ||
                                   (state.phase == SAHP_WAIT);

    sahp_bus_drv u_bus (
        .clk_in         (clk_in),
        .nrst_in        (nrst_in),
        .host_in        (host_in),
        .result_bits_in (state.sar),
        .busy_flag_in   (busy),
        .bus_out        (bus_out)
    );

    // =========================================================
    // checks
    sequence start_seq;
        !host_in.cs_n && !host_in.wr_n && !state.wr_q;
    endsequence

    chk_start_busy : assert property (@(posedge clk_in) disable iff (!nrst_in)
        start_seq |=> !busy_n_out)
        else $error("busy not asserted after start");
    chk_restart_sar : assert property (@(posedge clk_in) disable iff (!nrst_in)
        start_seq |=> (dac_code_out == 12'h800))
        else $error("conversion not restarted");
    chk_idle_busy_hi : assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state.phase == SAHP_IDLE) |-> busy_n_out)
        else $error("busy low while idle");
    chk_int_autozero : assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state.phase == SAHP_WAIT && !ext_clk_mode_in && $past(state.phase) == SAHP_ARMED)
        |-> (state.az_cnt == AZ_CNT_W'(AUTOZERO_CYC)))
        else $error("autozero skipped");
    chk_msb_edge : assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state.phase == SAHP_WAIT && ext_clk_mode_in && cclk_fall &&
         state.fall_cnt == EDGE_ZERO && !(wr_act && !state.wr_q))
        |=> (state.phase == SAHP_WAIT))
        else $error("msb taken on first falling edge");
    chk_msb_second : assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state.phase == SAHP_WAIT && ext_clk_mode_in && cclk_fall &&
         state.fall_cnt == EDGE_FIRST && !(wr_act && !state.wr_q))
        |=> (state.phase == SAHP_CONV))
        else $error("msb not taken on second falling edge");

endmodule
`default_nettype wire

// File: sahp_pkg.sv
// package for the converter host port: widths, phases, timing counts
// assumes a single 125 MHz system clock
package sahp_pkg;

    // =========================================================
    // widths and field positions
    localparam int RES_W          = 12;
    localparam int BUS_W          = 8;
    localparam int HI_PAD_W       = 3;
    localparam int HI_DATA_W      = 4;
    localparam int MSB_IDX        = 11;
    localparam int LO_MSB         = 7;
    localparam int HI_LSB         = 8;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int AUTOZERO_NS    = 10000;
    localparam int AUTOZERO_CYC   = (AUTOZERO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AZ_CNT_W       = 11;
    localparam int BIT_CNT_W      = 4;
    localparam int MSB_EDGE_NUM   = 2;
    localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 4'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 4'hb;
    localparam logic [1:0] EDGE_FIRST = 2'h1;
    localparam logic [1:0] EDGE_ZERO = 2'h0;

    // =========================================================
    // types
    typedef enum logic [1:0] {
        SAHP_IDLE,
        SAHP_ARMED,
        SAHP_WAIT,
        SAHP_CONV
    } sahp_phase_type;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic byte_select;
    } sahp_host_type;

    typedef struct packed {
        logic [BUS_W-1:0] data;
        logic [BUS_W-1:0] oe;
    } sahp_bus_type;

endpackage

// File: sahp_bus_drv.sv
// read-side data mux and three-state enables of the host port
// assumes host strobes synchronous to clk_in
`timescale 1ns/100ps
`default_nettype none
module sahp_bus_drv
    import sahp_pkg::*;
(
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    input  wire sahp_pkg::sahp_host_type     host_in,
    input  wire logic [sahp_pkg::RES_W-1:0]  result_bits_in,
    input  wire logic                        busy_flag_in,
    output var  sahp_pkg::sahp_bus_type      bus_out
);
    import sahp_pkg::*;

    typedef struct packed {
        sahp_bus_type bus;
    } sahp_drv_state_type;

    sahp_drv_state_type state;
    sahp_drv_state_type next_state;
    logic               read_on;

    function automatic logic [BUS_W-1:0] pick_byte(input logic hi,
                                                   input logic [RES_W-1:0] r,
                                                   input logic busy);
        if (hi) begin
            pick_byte = {busy, {HI_PAD_W{1'b0}}, r[MSB_IDX:HI_LSB]};
        end else begin
            pick_byte = r[LO_MSB:0];
        end
    endfunction

    // =========================================================
    // output data and enables
    always_comb begin
        read_on = !host_in.cs_n && !host_in.rd_n;
        next_state = state;
        next_state.bus.oe = {BUS_W{read_on}};
        next_state.bus.data = pick_byte(host_in.byte_select,
                                        result_bits_in, busy_flag_in);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign bus_out = state.bus;

    chk_oe_follows_read : assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!host_in.cs_n && !host_in.rd_n) |=> (bus_out.oe == {BUS_W{1'b1}}))
        else $error("data not driven during read");
    chk_oe_off_idle : assert property (@(posedge clk_in) disable iff (!nrst_in)
        (host_in.cs_n || host_in.rd_n) |=> (bus_out.oe == '0))
        else $error("data driven outside read");
    chk_hi_pad_zero : assert property (@(posedge clk_in) disable iff (!nrst_in)
        host_in.byte_select |=> (bus_out.data[6:4] == 3'h0))
        else $error("high byte pad not zero");
    chk_byte_swap : assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!host_in.cs_n && !host_in.rd_n && $changed(host_in.byte_select))
        |=> (bus_out.data == pick_byte($past(host_in.byte_select),
                                       $past(result_bits_in), $past(busy_flag_in))))
        else $error("data did not follow byte select");

endmodule
`default_nettype wire

// File: sahp_front.sv
// front-end model: conversion clock source and comparator
// assumes the sequencer keeps a trial bit while comp_out is one
`timescale 1ns/100ps
`default_nettype none
module sahp_front
    import sahp_pkg::*;
(
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    input  wire logic [sahp_pkg::RES_W-1:0]  target_in,
    input  wire logic [sahp_pkg::RES_W-1:0]  dac_code_in,
    output var  logic                        conv_clk_out,
    output var  logic                        comp_out
);
    // =========================================================
    // free-running conversion clock, eight system cycles a period
    logic [1:0] div;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div          <= 2'h0;
            conv_clk_out <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                conv_clk_out <= ~conv_clk_out;
            end
        end
    end
    // =========================================================
    // comparator: input at or above the trial code keeps the bit
    assign comp_out = (target_in >= dac_code_in);
endmodule
`default_nettype wire

// File: tb.sv
// testbench: host strobes, byte reads and conversions of the host port
// assumes sahp_pkg, sahp_top and sahp_front compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sahp_pkg::*;
    logic             clk_in;
    logic             nrst_in;
    sahp_host_type    host;
    logic             ext_mode;
    logic             conv_clk;
    logic             comp;
    logic [RES_W-1:0] dac;
    logic [RES_W-1:0] target;
    logic             busy_n;
    logic             az;
    sahp_bus_type     bus;
    int               n_mismatch = 0;
    int               checks = 0;

    sahp_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .host_in(host),
        .ext_clk_mode_in(ext_mode), .conv_clk_in(conv_clk), .comp_in(comp),
        .dac_code_out(dac), .autozero_cap_node_out(az), .busy_n_out(busy_n), .bus_out(bus));
    sahp_front model_u (.clk_in(clk_in), .nrst_in(nrst_in), .target_in(target),
        .dac_code_in(dac), .conv_clk_out(conv_clk), .comp_out(comp));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // =========================================================
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic wr(input int n, input logic cs);
        @(posedge clk_in);
        host.cs_n <= cs;
        host.wr_n <= 1'b0;
        repeat (n) @(posedge clk_in);
        host.cs_n <= 1'b1;
        host.wr_n <= 1'b1;
    endtask
    task automatic rd(input logic cs, input logic bs, output logic [7:0] d, output logic [7:0] oe);
        @(posedge clk_in);
        host.cs_n <= cs;
        host.rd_n <= 1'b0;
        host.byte_select <= bs;
        repeat (2) @(posedge clk_in);
        #1;
        d = bus.data;
        oe = bus.oe;
        @(posedge clk_in);
        host.cs_n <= 1'b1;
        host.rd_n <= 1'b1;
    endtask
    task automatic wait_done(output int n);
        n = 0;
        while (busy_n !== 1'b1 && n < 3000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask
    // =========================================================
    // scenarios
    task automatic t_reject;
        logic [7:0] d;
        logic [7:0] oe;
        wr(2, 1'b1);
        repeat (2) @(posedge clk_in);
        #1;
        chk({7'h00, busy_n}, 8'h01, "write without select");
        chk({7'h00, az}, 8'h01, "autozero while idle");
        rd(1'b1, 1'b1, d, oe);
        chk(oe, 8'h00, "read without select");
    endtask
    task automatic t_convert(input logic ext, input logic [RES_W-1:0] tgt);
        logic [7:0] d;
        logic [7:0] oe;
        int n;
        @(posedge clk_in);
        ext_mode <= ext;
        target <= tgt;
        wr(ext ? 1251 : 2, 1'b0);
        #1;
        chk({7'h00, busy_n}, 8'h00, "busy after start");
        rd(1'b0, 1'b1, d, oe);
        chk(d, 8'h88, "partial high byte");
        wait_done(n);
        if (ext) begin
            chk({7'h00, n >= 80 && n <= 120}, 8'h01, "external span");
        end else begin
            chk({7'h00, n >= 1240 && n < 1450}, 8'h01, "internal span");
        end
        rd(1'b0, 1'b1, d, oe);
        chk(d, {4'h0, tgt[11:8]}, "high byte");
        chk(oe, 8'hFF, "drive enable");
        rd(1'b0, 1'b0, d, oe);
        chk(d, tgt[7:0], "low byte");
        repeat (2) @(posedge clk_in);
        #1;
        chk(bus.oe, 8'h00, "bus released");
    endtask
    task automatic t_restart;
        logic [7:0] d;
        logic [7:0] oe;
        int n;
        @(posedge clk_in);
        ext_mode <= 1'b0;
        target <= 12'h3F1;
        wr(2, 1'b0);
        repeat (1300) @(posedge clk_in);
        #1;
        chk({7'h00, az}, 8'h00, "autozero during conversion");
        chk({7'h00, busy_n}, 8'h00, "busy during conversion");
        wr(2, 1'b0);
        wait_done(n);
        chk({7'h00, n >= 1240 && n < 1450}, 8'h01, "restart span");
        rd(1'b0, 1'b0, d, oe);
        chk(d, 8'hF1, "result after restart");
    endtask
    task automatic t_bytesel;
        @(posedge clk_in);
        host.cs_n <= 1'b0;
        host.rd_n <= 1'b0;
        host.byte_select <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        chk(bus.data, 8'hF1, "low before switch");
        @(posedge clk_in);
        host.byte_select <= 1'b1;
        @(posedge clk_in);
        #1;
        chk(bus.data, 8'h03, "high after switch");
        @(posedge clk_in);
        host.cs_n <= 1'b1;
        host.rd_n <= 1'b1;
    endtask
    // =========================================================
    // verdict, watchdog and main sequence
    task automatic give_verdict;
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        nrst_in = 1'b0;
        host = '{1'b1, 1'b1, 1'b1, 1'b0};
        ext_mode = 1'b0;
        target = 12'h000;
        @(posedge clk_in);
        #1;
        chk({bus.oe[6:0], busy_n}, 8'h01, "reset outputs");
        @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reject();
        t_convert(1'b0, 12'hA5C);
        t_convert(1'b1, 12'hFFF);
        t_convert(1'b0, 12'h000);
        t_restart();
        t_bytesel();
        give_verdict();
    end
endmodule
`default_nettype wire
